// file: rtl/bit_framing_tx_drive_control.sv
// Register bank for CRC high byte, bit framing and antenna driver control.
//
// What this block does
// R01: CRC high byte shows result MSB.
// R02: High byte undefined after 8-bit CRC.
// R03: First received bit lands at offset.
// R04: Receive offset clears after reception completes.
// R05: Send only final bit count bits.
// R06: Final bit count clears after transmission.
// R07: Select modulator input low, high, encoder, pin.
// R08: Invert bit inverts second driver carrier.
// R09: Unmodulated bit gives continuous second carrier.
// R10: Second driver enable gates modulated carrier.
// R11: First driver enable gates modulated carrier.
// R12: Software keeps fixed and reserved bits.
`timescale 1ns/1ps
module bit_framing_tx_drive_control (
  // Clock and reset
  input  wire logic       CLOCK_IN,
  input  wire logic       RESETN_IN,
  // Host register port
  input  wire logic [7:0] ADDR_IN,
  input  wire logic [7:0] WDATA_IN,
  input  wire logic       WRITE_IN,
  input  wire logic       READ_IN,
  output logic [7:0]      RDATA_OUT,
  // CRC coprocessor
  input  wire logic [7:0] CRC_HIGH_IN,
  input  wire logic       CRC_DONE_FLAG_IN,
  input  wire logic       CRC_EIGHT_BIT_IN,
  // Transmitter framing
  input  wire logic       TX_LAST_BYTE_IN,
  input  wire logic       TX_BIT_SENT_IN,
  input  wire logic       TX_DONE_IN,
  output logic            TX_BYTE_END_OUT,
  // Receiver framing
  input  wire logic       RX_START_IN,
  input  wire logic       RX_BIT_VALID_IN,
  input  wire logic       RX_BIT_IN,
  input  wire logic       RX_DONE_IN,
  output logic [7:0]      RX_BYTE_OUT,
  output logic [7:0]      RX_MASK_OUT,
  output logic            RX_BYTE_VALID_OUT,
  // Modulation and antenna
  input  wire logic       CARRIER_IN,
  input  wire logic       ENCODER_IN,
  input  wire logic       EXTERNAL_MODULATOR_PIN_IN,
  output logic            MODULATOR_OUT,
  output logic            ANTENNA_DRIVE_A_OUT,
  output logic            ANTENNA_DRIVE_B_OUT
);

  logic [7:0] bit_framing_adjust_reg;
  logic [7:0] antenna_drive_control_reg;
  logic [7:0] crc_high_reg;
  logic [2:0] tx_bit_count_reg;
  logic       wr_framing;
  logic       wr_drive;
  logic [2:0] tx_limit;

  framing_drive_pkg::framing_t    framing;
  framing_drive_pkg::drive_ctrl_t drive_ctrl;

  assign wr_framing = WRITE_IN && (ADDR_IN == framing_drive_pkg::ADDR_BIT_FRAMING_ADJUST);
  assign wr_drive   = WRITE_IN && (ADDR_IN == framing_drive_pkg::ADDR_ANTENNA_DRIVE_CONTROL);

  assign framing.rx_bit_offset =
    bit_framing_adjust_reg[framing_drive_pkg::RX_OFFSET_LSB +: 3];
  assign framing.tx_final_bit_count =
    bit_framing_adjust_reg[framing_drive_pkg::TX_FINAL_LSB +: 3];

  assign drive_ctrl.modulator_input_select = framing_drive_pkg::mod_select_t'(
    antenna_drive_control_reg[framing_drive_pkg::MOD_SEL_LSB +: 2]);
  assign drive_ctrl.drive_b_invert =
    antenna_drive_control_reg[framing_drive_pkg::DRIVE_B_INV];
  assign drive_ctrl.drive_b_unmodulated =
    antenna_drive_control_reg[framing_drive_pkg::DRIVE_B_CW];
  assign drive_ctrl.drive_b_carrier_enable =
    antenna_drive_control_reg[framing_drive_pkg::DRIVE_B_EN];
  assign drive_ctrl.drive_a_carrier_enable =
    antenna_drive_control_reg[framing_drive_pkg::DRIVE_A_EN];

  // Framing register: hardware clears win over a same-cycle software write,
  // because the write belongs to a frame that has already ended.
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      bit_framing_adjust_reg <= framing_drive_pkg::RESET_BIT_FRAMING_ADJUST;
    end else begin
      if (wr_framing) begin
        // Reserved bits 7 and 3 are kept at zero regardless of software.
        bit_framing_adjust_reg <= WDATA_IN & 8'h77; // R12
      end
      if (RX_DONE_IN) begin
        bit_framing_adjust_reg[framing_drive_pkg::RX_OFFSET_LSB +: 3] <= 3'h0; // R04
      end
      if (TX_DONE_IN) begin
        bit_framing_adjust_reg[framing_drive_pkg::TX_FINAL_LSB +: 3] <= 3'h0; // R06
      end
    end
  end

  // Driver control register; fixed bits are stored as written, software keeps them.
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      antenna_drive_control_reg <= framing_drive_pkg::RESET_ANTENNA_DRIVE_CONTROL;
    end else if (wr_drive) begin
      antenna_drive_control_reg <= WDATA_IN; // R12
    end
  end

  // CRC high byte is captured when the coprocessor finishes; for an 8-bit CRC the
  // byte is left as it was, which is undefined from the software point of view.
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      crc_high_reg <= 8'h00;
    end else if (CRC_DONE_FLAG_IN && !CRC_EIGHT_BIT_IN) begin
      crc_high_reg <= CRC_HIGH_IN; // R01 R02
    end
  end

  // Read data is registered, one cycle after the read strobe.
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      RDATA_OUT <= 8'h00;
    end else if (READ_IN) begin
      case (ADDR_IN)
        framing_drive_pkg::ADDR_CRC_RESULT_HIGH:       RDATA_OUT <= crc_high_reg; // R01
        framing_drive_pkg::ADDR_BIT_FRAMING_ADJUST:    RDATA_OUT <= bit_framing_adjust_reg;
        framing_drive_pkg::ADDR_ANTENNA_DRIVE_CONTROL: RDATA_OUT <= antenna_drive_control_reg;
        default:                                       RDATA_OUT <= 8'h00;
      endcase
    end
  end

  // Final transmit byte ends after the programmed bit count; zero means eight bits.
  assign tx_limit = (framing.tx_final_bit_count == 3'h0) ? 3'h7
                    : framing.tx_final_bit_count - 3'h1; // R05

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      tx_bit_count_reg <= 3'h0;
      TX_BYTE_END_OUT  <= 1'b0;
    end else begin
      TX_BYTE_END_OUT <= 1'b0;
      if (TX_DONE_IN) begin
        tx_bit_count_reg <= 3'h0;
      end else if (TX_BIT_SENT_IN) begin
        if (TX_LAST_BYTE_IN ? (tx_bit_count_reg == tx_limit) : (tx_bit_count_reg == 3'h7)) begin
          tx_bit_count_reg <= 3'h0; // R05
          TX_BYTE_END_OUT  <= 1'b1;
        end else begin
          tx_bit_count_reg <= tx_bit_count_reg + 3'h1;
        end
      end
    end
  end

  rx_bit_placer u_rx_bit_placer (
    .clock_in          (CLOCK_IN),
    .resetn_in         (RESETN_IN),
    .rx_start_in       (RX_START_IN),
    .rx_bit_offset_in  (framing.rx_bit_offset),
    .rx_bit_valid_in   (RX_BIT_VALID_IN),
    .rx_bit_in         (RX_BIT_IN),
    .rx_end_in         (RX_DONE_IN),
    .rx_byte_out       (RX_BYTE_OUT),
    .rx_mask_out       (RX_MASK_OUT),
    .rx_byte_valid_out (RX_BYTE_VALID_OUT)
  );

  antenna_driver_mux u_antenna_driver_mux (
    .clock_in                  (CLOCK_IN),
    .resetn_in                 (RESETN_IN),
    .ctrl_in                   (drive_ctrl),
    .carrier_in                (CARRIER_IN),
    .encoder_in                (ENCODER_IN),
    .external_modulator_pin_in (EXTERNAL_MODULATOR_PIN_IN),
    .drive_a_out               (ANTENNA_DRIVE_A_OUT),
    .drive_b_out               (ANTENNA_DRIVE_B_OUT),
    .modulator_out             (MODULATOR_OUT)
  );

  rx_clear_a: assert property (@(posedge CLOCK_IN) disable iff (!RESETN_IN)
    RX_DONE_IN |=> framing.rx_bit_offset == 3'h0) // R04
    else $error("Receive offset not cleared after reception.");
  tx_clear_a: assert property (@(posedge CLOCK_IN) disable iff (!RESETN_IN)
    TX_DONE_IN |=> framing.tx_final_bit_count == 3'h0) // R06
    else $error("Final bit count not cleared after transmission.");
  crc_read_a: assert property (@(posedge CLOCK_IN) disable iff (!RESETN_IN)
    (CRC_DONE_FLAG_IN && !CRC_EIGHT_BIT_IN) ##1
      (READ_IN && ADDR_IN == framing_drive_pkg::ADDR_CRC_RESULT_HIGH && !CRC_DONE_FLAG_IN)
      |=> RDATA_OUT == $past(CRC_HIGH_IN, 2)) // R01
    else $error("CRC high byte readback wrong.");
  tx_full_byte_a: assert property (@(posedge CLOCK_IN) disable iff (!RESETN_IN)
    (TX_BIT_SENT_IN && !TX_DONE_IN && TX_LAST_BYTE_IN && tx_bit_count_reg == tx_limit)
      |=> TX_BYTE_END_OUT && tx_bit_count_reg == 3'h0) // R05
    else $error("Final byte did not end at the bit count.");
  reserved_zero_a: assert property (@(posedge CLOCK_IN) disable iff (!RESETN_IN)
    wr_framing |=> (bit_framing_adjust_reg & 8'h88) == 8'h00) // R12
    else $error("Reserved framing bits not zero.");

endmodule

// file: common/framing_drive_pkg.sv
// Package with register map, field layout, reset values and control types for the framing block.
package framing_drive_pkg;

  // Register addresses on the host port.
  localparam logic [7:0] ADDR_CRC_RESULT_HIGH       = 8'h0e;
  localparam logic [7:0] ADDR_BIT_FRAMING_ADJUST    = 8'h0f;
  localparam logic [7:0] ADDR_ANTENNA_DRIVE_CONTROL = 8'h11;

  // Reset values.
  localparam logic [7:0] RESET_BIT_FRAMING_ADJUST    = 8'h00;
  localparam logic [7:0] RESET_ANTENNA_DRIVE_CONTROL = 8'h58;

  // Field positions of bit_framing_adjust.
  localparam int RX_OFFSET_LSB  = 4;
  localparam int TX_FINAL_LSB   = 0;
  // Field positions of antenna_drive_control.
  localparam int MOD_SEL_LSB    = 5;
  localparam int FIXED_ONE_BIT  = 4;
  localparam int DRIVE_B_INV    = 3;
  localparam int DRIVE_B_CW     = 2;
  localparam int DRIVE_B_EN     = 1;
  localparam int DRIVE_A_EN     = 0;

  // Constant level of a disabled driver.
  localparam logic DRIVER_IDLE_LEVEL = 1'b0;

  typedef enum logic [1:0] {
    MOD_LOW      = 2'b00,
    MOD_HIGH     = 2'b01,
    MOD_ENCODER  = 2'b10,
    MOD_EXTERNAL = 2'b11
  } mod_select_t;

  // Decoded driver control fields.
  typedef struct packed {
    mod_select_t modulator_input_select;
    logic        drive_b_invert;
    logic        drive_b_unmodulated;
    logic        drive_b_carrier_enable;
    logic        drive_a_carrier_enable;
  } drive_ctrl_t;

  // Framing fields toward the transmitter and receiver.
  typedef struct packed {
    logic [2:0] rx_bit_offset;
    logic [2:0] tx_final_bit_count;
  } framing_t;

endpackage

// file: rtl/antenna_driver_mux.sv
// Modulator source selection and carrier gating for both antenna drivers.
`timescale 1ns/1ps
module antenna_driver_mux (
  // Clock and reset
  input  wire logic                        clock_in,
  input  wire logic                        resetn_in,
  // Control
  input  wire framing_drive_pkg::drive_ctrl_t ctrl_in,
  // Signal sources
  input  wire logic                        carrier_in,
  input  wire logic                        encoder_in,
  input  wire logic                        external_modulator_pin_in,
  // Driver outputs
  output logic                             drive_a_out,
  output logic                             drive_b_out,
  output logic                             modulator_out
);

  logic mod_input;
  logic modulated;
  logic b_carrier;

  always_comb begin
    case (ctrl_in.modulator_input_select)
      framing_drive_pkg::MOD_LOW:      mod_input = 1'b0; // R07
      framing_drive_pkg::MOD_HIGH:     mod_input = 1'b1; // R07
      framing_drive_pkg::MOD_ENCODER:  mod_input = encoder_in; // R07
      framing_drive_pkg::MOD_EXTERNAL: mod_input = external_modulator_pin_in; // R07
      default:                         mod_input = 1'b0;
    endcase
  end

  // Modulation high lets the carrier through; low pauses it.
  assign modulated = carrier_in & mod_input;
  // The unmodulated choice keeps the raw carrier on the second driver.
  assign b_carrier = (ctrl_in.drive_b_unmodulated ? carrier_in : modulated) // R09
                     ^ ctrl_in.drive_b_invert; // R08

  // Outputs are registered so the top sees glitch-free levels.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      drive_a_out   <= framing_drive_pkg::DRIVER_IDLE_LEVEL;
      drive_b_out   <= framing_drive_pkg::DRIVER_IDLE_LEVEL;
      modulator_out <= 1'b0;
    end else begin
      drive_a_out   <= ctrl_in.drive_a_carrier_enable ? modulated
                       : framing_drive_pkg::DRIVER_IDLE_LEVEL; // R11
      drive_b_out   <= ctrl_in.drive_b_carrier_enable ? b_carrier
                       : framing_drive_pkg::DRIVER_IDLE_LEVEL; // R10
      modulator_out <= mod_input;
    end
  end

  drive_a_idle_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    !ctrl_in.drive_a_carrier_enable |=> drive_a_out == framing_drive_pkg::DRIVER_IDLE_LEVEL) // R11
    else $error("Drive a not idle while disabled.");
  drive_a_mod_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    ctrl_in.drive_a_carrier_enable |=> drive_a_out == $past(carrier_in & mod_input)) // R11
    else $error("Drive a does not follow the modulated carrier.");
  drive_b_idle_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    !ctrl_in.drive_b_carrier_enable |=> drive_b_out == framing_drive_pkg::DRIVER_IDLE_LEVEL) // R10
    else $error("Drive b not idle while disabled.");
  drive_b_cw_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (ctrl_in.drive_b_carrier_enable && ctrl_in.drive_b_unmodulated)
      |=> drive_b_out == ($past(carrier_in) ^ $past(ctrl_in.drive_b_invert))) // R09
    else $error("Drive b not the unmodulated carrier.");
  drive_b_inv_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (ctrl_in.drive_b_carrier_enable && ctrl_in.drive_b_invert && !ctrl_in.drive_b_unmodulated)
      |=> drive_b_out == !$past(modulated)) // R08
    else $error("Drive b not inverted.");
  mod_low_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    ctrl_in.modulator_input_select == framing_drive_pkg::MOD_LOW |=> !modulator_out) // R07
    else $error("Modulator input not low.");
  mod_ext_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    ctrl_in.modulator_input_select == framing_drive_pkg::MOD_EXTERNAL
      |=> modulator_out == $past(external_modulator_pin_in)) // R07
    else $error("Modulator input not from the external pin.");

endmodule

// file: rtl/rx_bit_placer.sv
// Places received bits into buffer bytes starting at the programmed bit offset.
`timescale 1ns/1ps
module rx_bit_placer (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       resetn_in,
  // Control
  input  wire logic       rx_start_in,
  input  wire logic [2:0] rx_bit_offset_in,
  input  wire logic       rx_bit_valid_in,
  input  wire logic       rx_bit_in,
  input  wire logic       rx_end_in,
  // Byte output
  output logic [7:0]      rx_byte_out,
  output logic [7:0]      rx_mask_out,
  output logic            rx_byte_valid_out
);

  logic [2:0] pos_reg;
  logic [7:0] byte_reg;
  logic [7:0] mask_reg;
  logic       active_reg;

  // A partial byte is flushed with its mask so the buffer can merge it.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pos_reg           <= 3'h0;
      byte_reg          <= 8'h00;
      mask_reg          <= 8'h00;
      active_reg        <= 1'b0;
      rx_byte_out       <= 8'h00;
      rx_mask_out       <= 8'h00;
      rx_byte_valid_out <= 1'b0;
    end else begin
      rx_byte_valid_out <= 1'b0;
      if (rx_start_in) begin
        pos_reg    <= rx_bit_offset_in; // R03
        byte_reg   <= 8'h00;
        mask_reg   <= 8'h00;
        active_reg <= 1'b1;
      end else if (active_reg && rx_bit_valid_in) begin
        pos_reg <= pos_reg + 3'h1; // R03
        if (pos_reg == 3'h7) begin
          rx_byte_out       <= byte_reg | ({7'h00, rx_bit_in} << pos_reg);
          rx_mask_out       <= mask_reg | 8'h80;
          rx_byte_valid_out <= 1'b1;
          byte_reg          <= 8'h00;
          mask_reg          <= 8'h00;
        end else begin
          byte_reg <= byte_reg | ({7'h00, rx_bit_in} << pos_reg);
          mask_reg <= mask_reg | (8'h01 << pos_reg);
        end
      end else if (active_reg && rx_end_in) begin
        active_reg        <= 1'b0;
        rx_byte_out       <= byte_reg;
        rx_mask_out       <= mask_reg;
        rx_byte_valid_out <= mask_reg != 8'h00;
      end
    end
  end

  first_bit_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    rx_start_in |=> pos_reg == $past(rx_bit_offset_in)) // R03
    else $error("First bit position differs from the offset.");
  wrap_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (active_reg && !rx_start_in && rx_bit_valid_in && pos_reg == 3'h7)
      |=> rx_byte_valid_out && pos_reg == 3'h0) // R03
    else $error("Bit 7 did not close the byte.");

endmodule

// file: verification/card_field_model.sv
// Card field model: free-running carrier and activity counters on both antenna drives.
`timescale 1ns/1ps
module card_field_model (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       resetn_in,
  // Antenna drives and counting window clear
  input  wire logic       clear_in,
  input  wire logic       drive_a_in,
  input  wire logic       drive_b_in,
  // Carrier and counters
  output logic            carrier_out,
  output logic [7:0]      rises_a_out,
  output logic [7:0]      rises_b_out,
  output logic [7:0]      match_b_out
);
  logic prev_a_reg;
  logic prev_b_reg;

  // The carrier toggles every cycle, so a gated drive shows a rise every second cycle.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) carrier_out <= 1'b0;
    else carrier_out <= ~carrier_out;
  end

  // A window counts drive rises and cycles where drive b equals the carrier.
  // The window clear is synchronous, so only reset stays asynchronous here.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rises_a_out <= 8'h00;
      rises_b_out <= 8'h00;
      match_b_out <= 8'h00;
    end else if (clear_in) begin
      rises_a_out <= 8'h00;
      rises_b_out <= 8'h00;
      match_b_out <= 8'h00;
    end else begin
      rises_a_out <= rises_a_out + {7'h00, drive_a_in & ~prev_a_reg};
      rises_b_out <= rises_b_out + {7'h00, drive_b_in & ~prev_b_reg};
      match_b_out <= match_b_out + {7'h00, drive_b_in === carrier_out};
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prev_a_reg <= 1'b0;
      prev_b_reg <= 1'b0;
    end else begin
      prev_a_reg <= drive_a_in;
      prev_b_reg <= drive_b_in;
    end
  end
endmodule

// file: verification/bit_framing_tx_drive_control_bench.sv
// Self-checking bench for the framing and antenna drive register bank.
`timescale 1ns/1ps
module bit_framing_tx_drive_control_bench;
  logic       clock, resetn, crc_eight, tx_last, rx_bit, enc, ext, carrier;
  logic       rdy_end, rx_valid, modulator, drive_a, drive_b;
  logic [7:0] addr, wdata, crc_high, rdata, rx_byte, rx_mask, rises_a, rises_b, match_b;
  // Strobes: tx bit, tx done, rx start, rx bit, rx done, crc done, write, read, clear.
  logic [8:0] strb;
  int         compares;
  int         miscompares;

  bit_framing_tx_drive_control i_dut (
    .CLOCK_IN(clock), .RESETN_IN(resetn), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WRITE_IN(strb[6]), .READ_IN(strb[7]), .RDATA_OUT(rdata), .CRC_HIGH_IN(crc_high),
    .CRC_DONE_FLAG_IN(strb[5]), .CRC_EIGHT_BIT_IN(crc_eight), .TX_LAST_BYTE_IN(tx_last),
    .TX_BIT_SENT_IN(strb[0]), .TX_DONE_IN(strb[1]), .TX_BYTE_END_OUT(rdy_end),
    .RX_START_IN(strb[2]), .RX_BIT_VALID_IN(strb[3]), .RX_BIT_IN(rx_bit),
    .RX_DONE_IN(strb[4]), .RX_BYTE_OUT(rx_byte), .RX_MASK_OUT(rx_mask),
    .RX_BYTE_VALID_OUT(rx_valid), .CARRIER_IN(carrier), .ENCODER_IN(enc),
    .EXTERNAL_MODULATOR_PIN_IN(ext), .MODULATOR_OUT(modulator),
    .ANTENNA_DRIVE_A_OUT(drive_a), .ANTENNA_DRIVE_B_OUT(drive_b));

  card_field_model i_field (
    .clock_in(clock), .resetn_in(resetn), .clear_in(strb[8]), .drive_a_in(drive_a),
    .drive_b_in(drive_b), .carrier_out(carrier), .rises_a_out(rises_a),
    .rises_b_out(rises_b), .match_b_out(match_b));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic pulse(input int k);
    @(posedge clock) strb[k] <= 1'b1;
    @(posedge clock) strb[k] <= 1'b0;
    #1;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) begin
      addr <= a;
      wdata <= d;
    end
    pulse(6);
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock) addr <= a;
    pulse(7);
    check(rdata, exp);
  endtask

  task automatic tx_run(input logic [2:0] cnt);
    int n;
    n = (cnt == 3'h0) ? 8 : int'(cnt);
    reg_write(8'h0f, {5'h00, cnt});
    @(posedge clock) tx_last <= 1'b1;
    for (int i = 1; i <= n; i++) begin
      pulse(0);
      check({7'h00, rdy_end}, {7'h00, i == n});
    end
    pulse(1);
    reg_read(8'h0f, 8'h00);
  endtask

  task automatic rx_run(input logic [2:0] off, input int n, input logic [15:0] bits);
    logic [7:0] eb;
    logic [7:0] em;
    int         pos;
    eb = 8'h00;
    em = 8'h00;
    pos = int'(off);
    reg_write(8'h0f, {1'b0, off, 4'h0});
    pulse(2);
    for (int i = 0; i < n; i++) begin
      @(posedge clock) rx_bit <= bits[i];
      pulse(3);
      eb[pos] = bits[i];
      em[pos] = 1'b1;
      check({7'h00, rx_valid}, {7'h00, pos == 7});
      if (pos == 7) begin
        check(rx_byte, eb);
        check(rx_mask, em);
        eb = 8'h00;
        em = 8'h00;
      end
      pos = (pos + 1) % 8;
    end
    pulse(4);
    if (em != 8'h00) begin
      check({rx_byte, rx_mask}, {eb, em});
    end
    reg_read(8'h0f, 8'h00);
  endtask

  // Settles the drives, then counts over a 20 cycle window of a toggling carrier.
  task automatic drv(input logic [7:0] ctrl, input logic e, input logic [7:0] ea,
                     input logic [7:0] eb, input logic [7:0] em);
    logic m;
    reg_write(8'h11, ctrl);
    @(posedge clock) begin
      enc <= e;
      ext <= ~e;
    end
    repeat (3) @(posedge clock);
    pulse(8);
    repeat (20) @(posedge clock);
    #1;
    case (ctrl[6:5])
      2'b00: m = 1'b0;
      2'b01: m = 1'b1;
      2'b10: m = e;
      default: m = ~e;
    endcase
    check({7'h00, modulator}, {7'h00, m});
    check(rises_a, ea);
    check(rises_b, eb);
    check(match_b, em);
  endtask

  task automatic print_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // The tests take about 430 cycles; the watchdog allows well beyond that.
  initial begin
    repeat (6000) @(posedge clock);
    miscompares++;
    print_verdict();
  end

  initial begin
    {resetn, addr, wdata, strb, crc_high, crc_eight, tx_last, rx_bit, enc, ext} = '0;
    compares = 0;
    miscompares = 0;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    reg_read(8'h0f, 8'h00);
    reg_read(8'h11, 8'h58);
    reg_read(8'h0e, 8'h00);
    reg_read(8'h10, 8'h00);
    reg_write(8'h0f, 8'hff);
    reg_read(8'h0f, 8'h77);
    reg_write(8'h0e, 8'h5a);
    reg_read(8'h0e, 8'h00);
    // Read straight after the done pulse, so the readback assertion is exercised.
    @(posedge clock) begin
      crc_high <= 8'ha5;
      addr <= 8'h0e;
    end
    @(posedge clock) strb[5] <= 1'b1;
    @(posedge clock) begin
      strb[5] <= 1'b0;
      strb[7] <= 1'b1;
    end
    @(posedge clock) strb[7] <= 1'b0;
    #1;
    check(rdata, 8'ha5);
    @(posedge clock) begin
      crc_high <= 8'h3c;
      crc_eight <= 1'b1;
    end
    pulse(5);
    reg_read(8'h0e, 8'ha5);
    tx_run(3'h3);
    tx_run(3'h0);
    rx_run(3'h7, 4, 16'h000d);
    rx_run(3'h3, 5, 16'h001b);
    rx_run(3'h0, 8, 16'h00a5);
    drv(8'h58, 1'b1, 8'd0, 8'd0, 8'd10);
    drv(8'h53, 1'b1, 8'd10, 8'd10, 8'd0);
    drv(8'h5b, 1'b1, 8'd10, 8'd10, 8'd20);
    drv(8'h53, 1'b0, 8'd0, 8'd0, 8'd10);
    drv(8'h57, 1'b0, 8'd0, 8'd10, 8'd0);
    drv(8'h51, 1'b1, 8'd10, 8'd0, 8'd10);
    drv(8'h33, 1'b0, 8'd10, 8'd10, 8'd0);
    drv(8'h13, 1'b1, 8'd0, 8'd0, 8'd10);
    drv(8'h73, 1'b1, 8'd0, 8'd0, 8'd10);
    print_verdict();
  end
endmodule
